// ==== rtl/mfc_cis_store.v ====
`timescale 1ns/10ps
`include "mfc_regs.vh"
module mfc_cis_store #(
	parameter IDX_W = 6
) (
	// Clock and reset
	input  wire             clk,
	input  wire             sys_rst,
	// EEPROM load stream
	input  wire             eeLoadValid,
	input  wire [7:0]       eeLoadAddr,
	input  wire [15:0]      eeLoadData,
	// Read side
	input  wire             rdEn,
	input  wire [IDX_W-1:0] rdIndex,
	output reg  [31:0]      rdData_q
);

	localparam WORDS = 1 << IDX_W;

	reg  [15:0] lowHalf  [0:WORDS-1];
	reg  [15:0] highHalf [0:WORDS-1];
	wire [8:0]  eeRel;
	wire        eeInCis;
	wire [IDX_W-1:0] wrIndex;

	// ==========================================================
	// Capture CIS words as the loader streams them
	assign eeRel   = {1'b0, eeLoadAddr} - {1'b0, `MFC_EE_CIS_BASE};
	assign eeInCis = (eeLoadAddr >= `MFC_EE_CIS_BASE) &&
	                 (eeRel < (2 * WORDS));
	assign wrIndex = eeRel[IDX_W:1];

	always @(posedge clk) begin
		if (eeLoadValid && eeInCis) begin // [RQ16]
			if (eeRel[0])
				highHalf[wrIndex] <= eeLoadData;
			else
				lowHalf[wrIndex] <= eeLoadData;
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rdData_q <= 32'h0000_0000;
		else if (rdEn)
			rdData_q <= {highHalf[rdIndex], lowHalf[rdIndex]}; // [RQ16]
	end

endmodule // mfc_cis_store

// ==== rtl/mfc_config_space.v ====
`timescale 1ns/10ps
`include "mfc_regs.vh"
module mfc_config_space (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// Configuration access
	input  wire        cfgReq,
	input  wire        cfgWrite,
	input  wire [2:0]  cfgFunc,
	input  wire [7:0]  cfgAddr,
	input  wire [3:0]  cfgByteEn,
	input  wire [31:0] cfgWrData,
	output reg         cfgAck_q,
	output reg  [31:0] cfgRdData_q,
	output wire        lanCfgSel,
	// EEPROM load stream
	input  wire        eeLoadValid,
	input  wire [7:0]  eeLoadAddr,
	input  wire [15:0] eeLoadData,
	// Memory window access
	input  wire        memReq,
	input  wire        memWrite,
	input  wire [31:0] memAddr,
	output reg         memAck_q,
	output wire [31:0] memRdData,
	output reg         ctrlSel_q,
	output reg         ctrlWrite_q,
	output reg  [7:0]  ctrlOffset_q,
	// I/O window access
	input  wire        ioReq,
	input  wire [31:0] ioAddr,
	output reg         ioSel_q,
	output reg  [2:0]  ioOffset_q,
	// Control state
	output wire        modemPresent,
	output wire        serrEnable,
	output wire        parityEnable
);

	localparam IO_L  = `MFC_IO_SIZE_LOG2;
	localparam MEM_L = `MFC_MEM_SIZE_LOG2;
	// 64 dwords fill the window above the control registers
	localparam CIS_W = 6;

	// ==========================================================
	// Byte-enable helpers
	function [31:0] laneMask;
		input [3:0] be;
		integer i;
		begin
			laneMask = 32'h0000_0000;
			for (i = 0; i < 4; i = i + 1)
				laneMask[i*8 +: 8] = {8{be[i]}};
		end
	endfunction

	function [31:0] mergeLanes;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [31:0] writable;
		input [3:0]  be;
		reg   [31:0] m;
		begin
			m = writable & laneMask(be);
			mergeLanes = (oldVal & ~m) | (newVal & m);
		end
	endfunction

	// ==========================================================
	// Register state
	reg         modemPresent_q;
	reg  [15:0] cmd_q;
	reg  [1:0]  stsWr_q;
	reg  [31:0] ident_q;
	reg  [7:0]  progIf_q;
	reg  [7:0]  revision_q;
	reg  [31:IO_L]  ioBase_q;
	reg  [31:MEM_L] memBase_q;

	reg  [15:0] cmd_d;
	reg  [1:0]  stsWr_d;
	reg  [31:0] ioBarMerged;
	reg  [31:0] memBarMerged;
	reg  [31:0] rdValue;

	wire [15:0] statusWord;
	wire [31:0] ioBarValue;
	wire [31:0] memBarValue;
	wire [31:0] cisPointer;
	wire [31:0] classWord;
	wire [31:0] headerWord;
	wire [7:0]  cfgDwordAddr;
	wire        modemCfg;
	wire        modemCfgWr;

	// ==========================================================
	// Function select
	assign cfgDwordAddr = {cfgAddr[7:2], 2'b00};
	assign modemCfg   = cfgReq && (cfgFunc == `MFC_FUNC_MODEM) &&
	                    modemPresent_q; // [RQ1] [RQ2]
	assign modemCfgWr = modemCfg && cfgWrite;
	// Function zero space lives elsewhere; hand it over
	assign lanCfgSel  = cfgReq && (cfgFunc == `MFC_FUNC_LAN); // [RQ1]

	// ==========================================================
	// EEPROM-loaded values
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modemPresent_q <= 1'b0;
			ident_q        <= `MFC_ID_RESET;
			progIf_q       <= `MFC_PROGIF_RESET;
			revision_q     <= `MFC_REV_RESET;
		end else if (eeLoadValid) begin
			case (eeLoadAddr)
				`MFC_EE_CONFIG: begin
					modemPresent_q <= eeLoadData[`MFC_EE_MODEM_BIT]; // [RQ2]
				end
				`MFC_EE_VENDOR: begin
					ident_q[15:0] <= eeLoadData; // [RQ3]
				end
				`MFC_EE_DEVICE: begin
					ident_q[31:16] <= eeLoadData; // [RQ3]
				end
				`MFC_EE_CLASS_REV: begin
					progIf_q   <= eeLoadData[15:8]; // [RQ10]
					revision_q <= eeLoadData[7:0]; // [RQ10]
				end
				default: begin
					modemPresent_q <= modemPresent_q;
				end
			endcase
		end
	end

	// ==========================================================
	// Writable fields, next values
	always @* begin
		cmd_d   = cmd_q;
		stsWr_d = stsWr_q;
		ioBarMerged  = {ioBase_q, {IO_L{1'b0}}};
		memBarMerged = {memBase_q, {MEM_L{1'b0}}};
		if (modemCfgWr) begin
			case (cfgDwordAddr)
				`MFC_OFF_CMD: begin
					// Only four command bits take writes
					if (cfgByteEn[1])
						cmd_d[`MFC_CMD_SERR_BIT] =
							cfgWrData[`MFC_CMD_SERR_BIT]; // [RQ4]
					if (cfgByteEn[0]) begin
						cmd_d[`MFC_CMD_PERR_BIT] =
							cfgWrData[`MFC_CMD_PERR_BIT]; // [RQ4]
						cmd_d[`MFC_CMD_MEM_BIT] =
							cfgWrData[`MFC_CMD_MEM_BIT]; // [RQ4]
						cmd_d[`MFC_CMD_IO_BIT] =
							cfgWrData[`MFC_CMD_IO_BIT]; // [RQ4]
					end
					// Plain read/write pair, not write-one-to-clear
					if (cfgByteEn[3])
						stsWr_d = {cfgWrData[16+`MFC_STS_WR_HI],
						           cfgWrData[16+`MFC_STS_WR_LO]}; // [RQ7]
				end
				`MFC_OFF_IO_BASE: begin
					ioBarMerged = mergeLanes(ioBarMerged, cfgWrData,
						~{{(32-IO_L){1'b0}}, {IO_L{1'b1}}},
						cfgByteEn); // [RQ12]
				end
				`MFC_OFF_MEM_BASE: begin
					memBarMerged = mergeLanes(memBarMerged, cfgWrData,
						~{{(32-MEM_L){1'b0}}, {MEM_L{1'b1}}},
						cfgByteEn); // [RQ13]
				end
				default: begin
					// Read-only and reserved words ignore writes
					cmd_d = cmd_q; // [RQ17]
				end
			endcase
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_q     <= `MFC_CMD_RESET; // [RQ4]
			stsWr_q   <= `MFC_STS_RESET; // [RQ6]
			ioBase_q  <= {(32-IO_L){1'b0}};
			memBase_q <= {(32-MEM_L){1'b0}};
		end else begin
			cmd_q     <= cmd_d;
			stsWr_q   <= stsWr_d;
			ioBase_q  <= ioBarMerged[31:IO_L];
			memBase_q <= memBarMerged[31:MEM_L];
		end
	end

	// ==========================================================
	// Read values
	// Fixed bits are ORed in; writable pair sits at bits 15:14
	assign statusWord = `MFC_STS_FIXED |
	                    {stsWr_q, 14'h0000}; // [RQ7] [RQ6]
	assign ioBarValue  = {ioBase_q, `MFC_IO_SPACE_FLAG}; // [RQ12]
	assign memBarValue = {memBase_q, `MFC_MEM_FLAGS}; // [RQ13]
	assign cisPointer  = {`MFC_CIS_PTR_OFS, `MFC_CIS_PTR_SPACE}; // [RQ15]
	assign classWord   = {`MFC_CLASS_BASE, `MFC_CLASS_SUB, progIf_q,
	                      revision_q}; // [RQ8] [RQ9]
	assign headerWord  = {8'h00, `MFC_HEADER_KIND, 16'h0000}; // [RQ11]

	always @* begin
		rdValue = 32'h0000_0000; // [RQ17]
		case (cfgDwordAddr)
			`MFC_OFF_ID: begin
				rdValue = ident_q; // [RQ3]
			end
			`MFC_OFF_CMD: begin
				// Master enable and the rest stay zero: never a master
				rdValue = {statusWord, cmd_q}; // [RQ5]
			end
			`MFC_OFF_CLASS: begin
				rdValue = classWord; // [RQ8] [RQ9] [RQ10]
			end
			`MFC_OFF_HEADER: begin
				rdValue = headerWord; // [RQ11]
			end
			`MFC_OFF_IO_BASE: begin
				rdValue = ioBarValue;
			end
			`MFC_OFF_MEM_BASE: begin
				rdValue = memBarValue;
			end
			`MFC_OFF_CIS_PTR: begin
				rdValue = cisPointer; // [RQ15]
			end
			default: begin
				rdValue = 32'h0000_0000; // [RQ17]
			end
		endcase
	end

	// Absent modem leaves function one unclaimed (master abort)
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfgAck_q    <= 1'b0;
			cfgRdData_q <= 32'h0000_0000;
		end else begin
			cfgAck_q <= modemCfg; // [RQ2]
			if (modemCfg && !cfgWrite)
				cfgRdData_q <= rdValue;
		end
	end

	// ==========================================================
	// Window decode
	wire             ioHit;
	wire [IO_L-1:0]  ioOff;
	wire             memHit;
	wire [MEM_L-1:0] memOff;
	wire [31:0]      cisStart;
	wire             cisAccess;
	wire             ctrlHit;

	// Absent modem keeps both windows closed
	mfc_window_decode #(
		.ADDR_W    (32),
		.SIZE_LOG2 (IO_L)
	) u_io_window (
		.req    (ioReq),
		.addr   (ioAddr),
		.base   (ioBase_q),
		.enable (cmd_q[`MFC_CMD_IO_BIT] & modemPresent_q), // [RQ4]
		.hit    (ioHit),
		.offset (ioOff)
	);

	mfc_window_decode #(
		.ADDR_W    (32),
		.SIZE_LOG2 (MEM_L)
	) u_mem_window (
		.req    (memReq),
		.addr   (memAddr),
		.base   (memBase_q),
		.enable (cmd_q[`MFC_CMD_MEM_BIT] & modemPresent_q), // [RQ4]
		.hit    (memHit),
		.offset (memOff)
	);

	// CIS sits above the control registers, at the pointer's offset
	assign cisStart  = {`MFC_CIS_PTR_OFS, 4'h0};
	assign cisAccess = memHit && (memOff >= cisStart[MEM_L-1:0]); // [RQ14]
	assign ctrlHit   = memHit && !cisAccess; // [RQ14]

	// ==========================================================
	// I/O window outputs
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ioSel_q    <= 1'b0;
			ioOffset_q <= 3'h0;
		end else begin
			ioSel_q <= ioHit; // [RQ12]
			// Offset holds between hits
			if (ioHit)
				ioOffset_q <= ioOff;
		end
	end

	// ==========================================================
	// Memory window outputs
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlSel_q    <= 1'b0;
			ctrlWrite_q  <= 1'b0;
			ctrlOffset_q <= 8'h00;
			memAck_q     <= 1'b0;
		end else begin
			ctrlSel_q   <= ctrlHit; // [RQ14]
			ctrlWrite_q <= ctrlHit && memWrite;
			// CIS is read-only; writes there are acknowledged and dropped
			memAck_q    <= cisAccess; // [RQ14]
			if (ctrlHit)
				ctrlOffset_q <= memOff[7:0];
		end
	end

	wire [MEM_L-1:0] cisRel;
	assign cisRel = memOff - cisStart[MEM_L-1:0];

	mfc_cis_store #(
		.IDX_W (CIS_W)
	) u_cis (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.eeLoadValid (eeLoadValid),
		.eeLoadAddr  (eeLoadAddr),
		.eeLoadData  (eeLoadData),
		.rdEn        (cisAccess && !memWrite),
		.rdIndex     (cisRel[7:2]),
		.rdData_q    (memRdData) // [RQ16]
	);

	// ==========================================================
	// Control state
	assign modemPresent = modemPresent_q;
	assign serrEnable   = cmd_q[`MFC_CMD_SERR_BIT];
	assign parityEnable = cmd_q[`MFC_CMD_PERR_BIT];

endmodule // mfc_config_space

// ==== rtl/mfc_regs.vh ====
// Function
// [RQ1] Network function zero, modem function one
// [RQ2] Modem presence follows loaded EEPROM configuration
// [RQ3] Identification word read-only, loaded from EEPROM
// [RQ4] Command resets zero; enables gate modem accesses
// [RQ5] Other command bits read zero; never master
// [RQ6] Status word cleared by bus reset
// [RQ7] Status: 15,14 writable; timing 01; capability 1
// [RQ8] Class/revision word read-only, EEPROM loaded
// [RQ9] Class code 07H, 00H, interface 02H
// [RQ10] Interface and revision bytes from word FEH
// [RQ11] Header type fixed 80H, multifunction
// [RQ12] I/O window requests eight bytes
// [RQ13] Memory window requests 512 bytes
// [RQ14] Memory window reaches control registers and CIS
// [RQ15] CIS pointer fixed: offset 0010H, space 2H
// [RQ16] CIS reads return EEPROM-stored contents
// [RQ17] Reserved doublewords read zero, ignore writes
`ifndef MFC_REGS_VH
`define MFC_REGS_VH

// ==========================================================
// Function numbers
`define MFC_FUNC_LAN        3'h0
`define MFC_FUNC_MODEM      3'h1

// ==========================================================
// Configuration offsets (byte addresses)
`define MFC_OFF_ID          8'h00
`define MFC_OFF_CMD         8'h04
`define MFC_OFF_CLASS       8'h08
`define MFC_OFF_HEADER      8'h0C
`define MFC_OFF_IO_BASE     8'h10
`define MFC_OFF_MEM_BASE    8'h14
`define MFC_OFF_CIS_PTR     8'h28

// ==========================================================
// Command and status fields
`define MFC_CMD_IO_BIT      0
`define MFC_CMD_MEM_BIT     1
`define MFC_CMD_PERR_BIT    6
`define MFC_CMD_SERR_BIT    8
`define MFC_CMD_RESET       16'h0000
`define MFC_STS_WR_HI       15
`define MFC_STS_WR_LO       14
`define MFC_STS_FIXED       16'h0210
`define MFC_STS_RESET       2'h0

// ==========================================================
// Class, header, windows, CIS pointer
`define MFC_CLASS_BASE      8'h07
`define MFC_CLASS_SUB       8'h00
`define MFC_PROGIF_RESET    8'h02
`define MFC_REV_RESET       8'h00
`define MFC_HEADER_KIND     8'h80
`define MFC_IO_SIZE_LOG2    3
`define MFC_MEM_SIZE_LOG2   9
`define MFC_IO_SPACE_FLAG   3'h1
`define MFC_MEM_FLAGS       9'h000
`define MFC_CIS_PTR_OFS     28'h000_0010
`define MFC_CIS_PTR_SPACE   4'h2

// ==========================================================
// EEPROM word addresses
`define MFC_EE_VENDOR       8'h30
`define MFC_EE_DEVICE       8'h31
`define MFC_EE_CONFIG       8'h32
`define MFC_EE_MODEM_BIT    0
`define MFC_EE_CLASS_REV    8'hFE
`define MFC_EE_CIS_BASE     8'h40
`define MFC_ID_RESET        32'h0000_0000

`endif

// ==== rtl/mfc_window_decode.v ====
`timescale 1ns/10ps
module mfc_window_decode #(
	parameter ADDR_W    = 32,
	parameter SIZE_LOG2 = 3
) (
	// Access
	input  wire                  req,
	input  wire [ADDR_W-1:0]     addr,
	// Window
	input  wire [ADDR_W-1:SIZE_LOG2] base,
	input  wire                  enable,
	// Result
	output wire                  hit,
	output wire [SIZE_LOG2-1:0]  offset
);

	// ==========================================================
	// Naturally aligned window compare
	assign hit    = req & enable & (addr[ADDR_W-1:SIZE_LOG2] == base);
	assign offset = addr[SIZE_LOG2-1:0];

endmodule // mfc_window_decode

// ==== sim/mfc_config_space_checker.sv ====
`timescale 1ns/10ps
module mfc_config_space_checker (
	// Clock and reset
	input wire        clk,
	input wire        sys_rst,
	// Configuration bus
	input wire        cfgReq,
	input wire        cfgWrite,
	input wire [2:0]  cfgFunc,
	input wire [7:0]  cfgAddr,
	input wire [3:0]  cfgByteEn,
	input wire [31:0] cfgWrData,
	input wire        cfgAck_q,
	input wire [31:0] cfgRdData_q,
	input wire        lanCfgSel,
	// State and windows
	input wire        modemPresent,
	input wire        parityEnable,
	input wire        memReq,
	input wire        memAck_q,
	input wire        ctrlSel_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [5:0] rdWd_q;
	wire        takenW = cfgReq && cfgFunc == 3'h1 && modemPresent;
	// Doubleword of the read being answered; 3F means none
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rdWd_q <= 6'h3F;
		else
			rdWd_q <= (takenW && !cfgWrite) ? cfgAddr[7:2] : 6'h3F;
	end
	a_ack_taken: assert property (takenW |=> cfgAck_q)
		else $error("ack missing");
	a_ack_refused: assert property (!takenW |=> !cfgAck_q)
		else $error("ack without request");
	a_lan_select: assert property (
		lanCfgSel == (cfgReq && cfgFunc == 3'h0))
		else $error("lan select wrong");
	a_status_fixed: assert property (cfgAck_q && rdWd_q == 6'h01 |->
		(cfgRdData_q & 32'h3FFF_FEBC) == 32'h0210_0000)
		else $error("status or command fixed bits wrong");
	a_class_code: assert property (cfgAck_q && rdWd_q == 6'h02 |->
		cfgRdData_q[31:16] == 16'h0700) else $error("class code wrong");
	a_header_fixed: assert property (cfgAck_q && rdWd_q == 6'h03 |->
		cfgRdData_q == 32'h0080_0000) else $error("header wrong");
	a_cis_pointer: assert property (cfgAck_q && rdWd_q == 6'h0A |->
		cfgRdData_q == 32'h0000_0102) else $error("cis pointer wrong");
	a_parity_write: assert property (takenW && cfgWrite &&
		cfgAddr[7:2] == 6'h01 && cfgByteEn[0] |=>
		parityEnable == $past(cfgWrData[6])) else $error("parity enable");
	a_window_split: assert property ((memAck_q || ctrlSel_q) |->
		!(memAck_q && ctrlSel_q) && $past(memReq))
		else $error("window answer without one request");
endmodule // mfc_config_space_checker

bind mfc_config_space mfc_config_space_checker u_mfc_config_space_checker (
	.clk, .sys_rst, .cfgReq, .cfgWrite, .cfgFunc, .cfgAddr, .cfgByteEn,
	.cfgWrData, .cfgAck_q, .cfgRdData_q, .lanCfgSel, .modemPresent,
	.parityEnable, .memReq, .memAck_q, .ctrlSel_q);

// ==== sim/mfc_config_space_tb.sv ====
`timescale 1ns/10ps
module mfc_config_space_tb;
	logic        clk, sys_rst, cfgReq, cfgWrite, cfgAck_q, lanCfgSel;
	logic [2:0]  cfgFunc, ioOffset_q;
	logic [7:0]  cfgAddr, eeLoadAddr, ctrlOffset_q, rowAddr;
	logic [3:0]  cfgByteEn;
	logic [31:0] cfgWrData, cfgRdData_q, memAddr, memRdData, ioAddr, rd;
	logic [15:0] eeLoadData;
	logic        eeLoadValid, memReq, memWrite, memAck_q, ctrlSel_q;
	logic        ctrlWrite_q, ioReq, ioSel_q, modemPresent, ack;
	logic        serrEnable, parityEnable;
	int          failures, compares, cycles, i;
	logic [39:0] rows [12] = '{
		{8'h00, 32'hA5A5_5A5A},
		{8'h04, 32'h0210_0000},
		{8'h08, 32'h0700_02A5},
		{8'h0C, 32'h0080_0000},
		{8'h10, 32'h0000_0001},
		{8'h14, 32'h0000_0000},
		{8'h18, 32'h0000_0000}, {8'h1C, 32'h0000_0000},
		{8'h20, 32'h0000_0000}, {8'h24, 32'h0000_0000},
		{8'h28, 32'h0000_0102}, {8'h2C, 32'h0000_0000}};

	mfc_host_model u_mfc_host_model (.clk(clk), .cfgReq(cfgReq),
		.cfgWrite(cfgWrite), .cfgFunc(cfgFunc), .cfgAddr(cfgAddr),
		.cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
		.cfgAck_q(cfgAck_q), .cfgRdData_q(cfgRdData_q));
	mfc_config_space u_mfc_config_space (.clk(clk), .sys_rst(sys_rst),
		.cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgFunc(cfgFunc),
		.cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
		.cfgAck_q(cfgAck_q), .cfgRdData_q(cfgRdData_q),
		.lanCfgSel(lanCfgSel), .eeLoadValid(eeLoadValid),
		.eeLoadAddr(eeLoadAddr), .eeLoadData(eeLoadData), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memAck_q(memAck_q),
		.memRdData(memRdData), .ctrlSel_q(ctrlSel_q),
		.ctrlWrite_q(ctrlWrite_q), .ctrlOffset_q(ctrlOffset_q),
		.ioReq(ioReq), .ioAddr(ioAddr), .ioSel_q(ioSel_q),
		.ioOffset_q(ioOffset_q), .modemPresent(modemPresent),
		.serrEnable(serrEnable), .parityEnable(parityEnable));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task stop_test;
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs about 115 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cfg(input logic wr, input logic [2:0] fn, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		u_mfc_host_model.cfg(wr, fn, a, be, d, ack, rd);
	endtask

	task ee(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		eeLoadValid = 1'b1;
		eeLoadAddr = a;
		eeLoadData = d;
		@(negedge clk);
		eeLoadValid = 1'b0;
	endtask

	// Identity values are arbitrary
	task load;
		ee(8'h30, 16'h5A5A);
		ee(8'h31, 16'hA5A5);
		ee(8'hFE, 16'h02A5);
		ee(8'h42, 16'hBEEF);
		ee(8'h43, 16'hCAFE);
		ee(8'h32, 16'h0001);
	endtask

	task win(input logic mem, input logic wr, input logic [31:0] a);
		@(negedge clk);
		memReq = mem;
		memWrite = wr;
		memAddr = a;
		ioReq = !mem;
		ioAddr = a;
		@(negedge clk);
		memReq = 1'b0;
		ioReq = 1'b0;
		memAddr = ~a;
		ioAddr = ~a;
	endtask

	initial begin
		sys_rst = 1'b1;
		{eeLoadValid, memReq, memWrite, ioReq} = 4'h0;
		{eeLoadAddr, eeLoadData, memAddr, ioAddr} = 88'h0;
		repeat (3) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		cfg(1'b0, 3'h1, 8'h00, 4'hF, 32'h0000_0000);
		chk({31'h0, ack}, 32'h0);
		chk({31'h0, modemPresent}, 32'h0);
		load;
		chk({31'h0, modemPresent}, 32'h1);
		cfg(1'b0, 3'h2, 8'h00, 4'hF, 32'h0000_0000);
		chk({31'h0, ack}, 32'h0);
		cfg(1'b0, 3'h0, 8'h00, 4'hF, 32'h0000_0000);
		chk({31'h0, ack}, 32'h0);
		for (i = 0; i < 12; i++) begin
			rowAddr = rows[i][39:32];
			if (i != 1 && i != 4 && i != 5)
				cfg(1'b1, 3'h1, rowAddr, 4'hF, 32'hFFFF_FFFF);
			cfg(1'b0, 3'h1, rowAddr, 4'hF, 32'h0000_0000);
			chk({31'h0, ack}, 32'h1);
			chk(rd, rows[i][31:0]);
		end
		cfg(1'b1, 3'h1, 8'h04, 4'hF, 32'hFFFF_FFFF);
		cfg(1'b0, 3'h1, 8'h04, 4'hF, 32'h0000_0000);
		chk(rd, 32'hC210_0143);
		chk({30'h0, serrEnable, parityEnable}, 32'h3);
		cfg(1'b1, 3'h1, 8'h10, 4'hF, 32'hFFFF_FFFF);
		cfg(1'b0, 3'h1, 8'h10, 4'hF, 32'h0000_0000);
		chk(rd, 32'hFFFF_FFF9);
		cfg(1'b1, 3'h1, 8'h14, 4'hF, 32'hFFFF_FFFF);
		cfg(1'b0, 3'h1, 8'h14, 4'hF, 32'h0000_0000);
		chk(rd, 32'hFFFF_FE00);
		cfg(1'b1, 3'h1, 8'h10, 4'hF, 32'h0000_1000);
		cfg(1'b1, 3'h1, 8'h14, 4'hF, 32'h0001_0000);
		win(1'b0, 1'b0, 32'h0000_1005);
		chk({28'h0, ioSel_q, ioOffset_q}, 32'hD);
		win(1'b0, 1'b0, 32'h0000_1008);
		// Offset keeps the last hit; only the select drops
		chk({28'h0, ioSel_q, ioOffset_q}, 32'h5);
		win(1'b1, 1'b0, 32'h0001_0104);
		chk({31'h0, memAck_q}, 32'h1);
		chk(memRdData, 32'hCAFE_BEEF);
		win(1'b1, 1'b1, 32'h0001_0020);
		chk({22'h0, ctrlSel_q, ctrlWrite_q, ctrlOffset_q}, 32'h320);
		win(1'b1, 1'b0, 32'h0001_0200);
		chk({30'h0, memAck_q, ctrlSel_q}, 32'h0);
		cfg(1'b1, 3'h1, 8'h04, 4'h1, 32'h0000_0000);
		win(1'b0, 1'b0, 32'h0000_1005);
		chk({31'h0, ioSel_q}, 32'h0);
		win(1'b1, 1'b0, 32'h0001_0104);
		chk({31'h0, memAck_q}, 32'h0);
		@(negedge clk) sys_rst = 1'b1;
		@(negedge clk) sys_rst = 1'b0;
		chk({30'h0, modemPresent, serrEnable}, 32'h0);
		cfg(1'b0, 3'h1, 8'h04, 4'hF, 32'h0000_0000);
		chk({31'h0, ack}, 32'h0);
		load;
		cfg(1'b0, 3'h1, 8'h04, 4'hF, 32'h0000_0000);
		chk(rd, 32'h0210_0000);
		stop_test;
	end
endmodule // mfc_config_space_tb

// ==== sim/mfc_host_model.sv ====
`timescale 1ns/10ps
module mfc_host_model (
	// Clock
	input  wire         clk,
	// Request
	output logic        cfgReq,
	output logic        cfgWrite,
	output logic [2:0]  cfgFunc,
	output logic [7:0]  cfgAddr,
	output logic [3:0]  cfgByteEn,
	output logic [31:0] cfgWrData,
	// Answer
	input  wire         cfgAck_q,
	input  wire  [31:0] cfgRdData_q
);
	initial begin
		cfgReq = 1'b0;
		cfgWrite = 1'b0;
		cfgFunc = 3'h7;
		cfgAddr = 8'hFF;
		cfgByteEn = 4'h0;
		cfgWrData = 32'h0000_0000;
	end

	// One-cycle pulse; answer taken at the following falling edge
	task automatic cfg(input logic wr, input logic [2:0] fn,
		input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
		output logic ack, output logic [31:0] r);
		@(negedge clk);
		cfgReq = 1'b1;
		cfgWrite = wr;
		cfgFunc = fn;
		cfgAddr = a;
		cfgByteEn = be;
		cfgWrData = d;
		@(negedge clk);
		ack = cfgAck_q;
		r = cfgRdData_q;
		cfgReq = 1'b0;
		// Released lines must not look like a held value
		cfgAddr = ~a;
		cfgWrData = ~d;
	endtask
endmodule // mfc_host_model
